// ===== lrf_pkg.sv
// Shared constants and types of the legacy receive frame builder.
`default_nettype none
package lrf_pkg;
  // Frame bytes and field layout.
  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] TYPE_RX16 = 8'h81;
  localparam logic [7:0] TYPE_IO64 = 8'h82;
  localparam logic [7:0] FMT_LEGACY = 8'h02;
  localparam logic [15:0] ADDR_NONE = 16'hfffe;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  localparam logic [7:0] SAMPLE_SETS = 8'h01;
  localparam logic [8:0] SUM_FIRST = 9'h003;
  localparam logic [8:0] DATA_HDR_LAST = 9'h007;
  localparam logic [8:0] SAMP_HDR_LAST = 9'h010;
  localparam logic [8:0] LONG_LAST = 9'h00b;
  localparam logic [15:0] DATA_LEN_BASE = 16'h0005;
  localparam logic [15:0] SAMP_LEN_BASE = 16'h000e;
  localparam int DIG_LAST = 8;
  localparam int ANA_FIRST = 9;
  localparam int ANA_COUNT = 4;
  localparam int TAIL_W = 80;
  // Register map.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_FRAMES = 12'h008;
  localparam logic [11:0] REG_DROPS = 12'h00c;
  localparam int CTRL_API_BIT = 8;
  localparam logic [7:0] CTRL_FMT_RESET = 8'h00;
  localparam logic CTRL_API_RESET = 1'b0;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_HEAD = 6'h02,
    ST_PAY = 6'h04,
    ST_TAIL = 6'h08,
    ST_SUM = 6'h10,
    ST_DROP = 6'h20
  } lrf_state_t;
endpackage
`default_nettype wire

// ===== lrf_sum_if.sv
// Link between the frame sequencer and its checksum unit.
`timescale 1ns/1ps
`default_nettype none
interface lrf_sum_if;
  logic clr;
  logic add;
  logic [7:0] data;
  logic [7:0] csum;
  modport owner(output clr, output add, output data, input csum);
  modport unit(input clr, input add, input data, output csum);
endinterface
`default_nettype wire

// ===== lrf_csum.sv
// Running checksum of the frame bytes that follow the length field.
`timescale 1ns/1ps
`default_nettype none
module lrf_csum (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Byte feed.
  lrf_sum_if.unit sum
);
  logic [7:0] sum_q;
  logic [7:0] sum_d;

  always_comb begin
    sum_d = sum_q;
    if (sum.clr) begin
      sum_d = 8'h00;
    end else if (sum.add) begin
      sum_d = sum_q + sum.data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sum_q <= 8'h00;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign sum.csum = lrf_pkg::CSUM_BASE - sum_q; // RL7
endmodule
`default_nettype wire

// ===== lrf_builder.sv
// Builder of the short-address receive and long-address sample frames.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1: With the format option at 2, a data packet from a short address below 0xfffe becomes a 0x81 frame; the code frames it only in frame-based mode.
// RL2: Each frame opens with 0x7e and a 16-bit length counting the bytes between length and checksum.
// RL3: The short-address receive frame carries type 0x81 at offset 3.
// RL4: That frame holds the 16-bit source at 4, strength at 6, options at 7 and payload from 8.
// RL5: The strength byte is the magnitude of the negative dBm level, so -40 dBm gives 0x28.
// RL6: Options bit 0 is reserved, bit 1 marks broadcast, bit 2 marks all-network broadcast.
// RL7: The last byte is 0xff minus the low byte of the sum of bytes from offset 3 on.
// RL8: With the format option at 2, a sample frame from short address 0xfffe becomes a 0x82 frame.
// RL9: Sample frames leave only while the frame-based mode is on, never in transparent mode.
// RL10: The sample frame holds the 64-bit source at 4, strength 12, options 13, set count 14, mask 15.
// RL11: Mask bits 0-8 are digital lines, 9-12 analog channels, 13-15 unused and zero.
// RL12: The digital word at 17 appears only for a nonzero digital mask and masks off idle lines.
// RL13: Enabled analog values follow as 16-bit words from channel 0 up to channel 3.
// RL14: The host hunts for 0x7e, takes the counted bytes and drops frames whose checksum fails; lrf_host keeps them and counts them in bad_cnt.
module lrf_builder #(
  parameter int ADDR_W = 12,
  parameter int PAY_W = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Received packet descriptor.
  input wire logic i_pkt_valid,
  output logic o_pkt_ready,
  input wire logic i_pkt_kind,
  input wire logic [15:0] i_src_short,
  input wire logic [63:0] i_src_long,
  input wire logic [7:0] i_rssi_dbm,
  input wire logic i_bcast,
  input wire logic i_bcast_all_net,
  input wire logic [PAY_W-1:0] i_pay_len,
  input wire logic [15:0] i_chan_mask,
  input wire logic [15:0] i_dig_samples,
  input wire logic [63:0] i_analog,
  // Payload byte stream.
  input wire logic i_pay_valid,
  output logic o_pay_ready,
  input wire logic [7:0] i_pay_data,
  // Serial frame byte stream.
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [7:0] o_tx_data
);
  if (PAY_W < 1 || PAY_W > 8 || ADDR_W < 4) begin : g_bad_param
    $error("lrf_builder: unsupported parameter values");
  end

  lrf_sum_if sum();
  lrf_csum u_csum (.i_clk(i_clk), .i_reset_n(i_reset_n), .sum(sum));

  // Control registers and APB access.
  logic [7:0] fmt_q, fmt_d;
  logic api_q, api_d;
  logic [15:0] frames_q, frames_d, drops_q, drops_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic [11:0] ra;
  logic hit;
  logic [31:0] rv;
  lrf_pkg::lrf_state_t state_q, state_d;
  logic tx_valid_q, tx_valid_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic frame_done;
  logic drop_evt;

  assign ra = 12'(i_paddr);
  always_comb begin
    hit = 1'b1;
    rv = 32'h0000_0000;
    case (ra)
      lrf_pkg::REG_CTRL: rv = {23'h0, api_q, fmt_q};
      lrf_pkg::REG_STATUS: rv = {30'h0, tx_valid_q,
                                 state_q != lrf_pkg::ST_IDLE};
      lrf_pkg::REG_FRAMES: rv = {16'h0, frames_q};
      lrf_pkg::REG_DROPS: rv = {16'h0, drops_q};
      default: hit = 1'b0;
    endcase
    fmt_d = fmt_q;
    api_d = api_q;
    rdata_d = rdata_q;
    err_d = err_q;
    if (i_psel && !i_penable) begin
      rdata_d = i_pwrite ? 32'h0000_0000 : rv;
      err_d = !hit;
    end
    if (i_psel && i_penable && i_pwrite && ra == lrf_pkg::REG_CTRL) begin
      if (i_pstrb[0]) begin
        fmt_d = i_pwdata[7:0];
      end
      if (i_pstrb[1]) begin
        api_d = i_pwdata[lrf_pkg::CTRL_API_BIT];
      end
    end
    frames_d = frames_q + (frame_done ? 16'h0001 : 16'h0000);
    drops_d = drops_q + (drop_evt ? 16'h0001 : 16'h0000);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fmt_q <= lrf_pkg::CTRL_FMT_RESET;
      api_q <= lrf_pkg::CTRL_API_RESET;
      frames_q <= 16'h0000;
      drops_q <= 16'h0000;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      fmt_q <= fmt_d;
      api_q <= api_d;
      frames_q <= frames_d;
      drops_q <= drops_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = rdata_q;
  assign o_pslverr = err_q;

  // Packet decode and sample tail assembly.
  logic emit_ok, want16, want64;
  logic [7:0] rssi_mag;
  logic [15:0] dig_w;
  logic [lrf_pkg::TAIL_W-1:0] tail_v;
  logic [3:0] tail_n;

  assign emit_ok = api_q && (fmt_q == lrf_pkg::FMT_LEGACY); // RL9
  assign want16 = !i_pkt_kind && (i_src_short < lrf_pkg::ADDR_NONE); // RL1
  assign want64 = i_pkt_kind && (i_src_short == lrf_pkg::ADDR_NONE); // RL8
  assign rssi_mag = i_rssi_dbm[7] ? 8'h00 - i_rssi_dbm : 8'h00; // RL5
  assign dig_w = {7'h00, i_dig_samples[8:0] & i_chan_mask[8:0]}; // RL12

  always_comb begin
    tail_v = '0;
    tail_n = 4'h0;
    // Pushing from channel 3 downward leaves channel 0 first.
    for (int c = lrf_pkg::ANA_COUNT - 1; c >= 0; c--) begin
      if (i_chan_mask[lrf_pkg::ANA_FIRST + c]) begin // RL13
        tail_v = {i_analog[16*c +: 16], tail_v[lrf_pkg::TAIL_W-1:16]};
        tail_n = tail_n + 4'h2;
      end
    end
    if (|i_chan_mask[lrf_pkg::DIG_LAST:0]) begin // RL12
      tail_v = {dig_w, tail_v[lrf_pkg::TAIL_W-1:16]};
      tail_n = tail_n + 4'h2;
    end
  end

  // Frame sequencer.
  logic kind_q, kind_d;
  logic [15:0] src_q, src_d, mask_q, mask_d, len_q, len_d;
  logic [63:0] long_q, long_d;
  logic [7:0] rssi_q, rssi_d, raw_q, raw_d, opt_q, opt_d;
  logic [lrf_pkg::TAIL_W-1:0] tail_q, tail_d;
  logic [3:0] tail_n_q, tail_n_d;
  logic [PAY_W-1:0] left_q, left_d;
  logic [8:0] idx_q, idx_d, pos_q, pos_d;
  logic last_q, last_d;
  logic slot_free, load;
  logic [7:0] byte_v, hdr_b;
  logic [2:0] lsel;

  assign slot_free = !tx_valid_q || i_tx_ready;
  assign lsel = 3'(lrf_pkg::LONG_LAST - idx_q);

  always_comb begin
    hdr_b = 8'h00;
    case (idx_q)
      9'h000: hdr_b = lrf_pkg::START_DELIM; // RL2
      9'h001: hdr_b = len_q[15:8];
      9'h002: hdr_b = len_q[7:0];
      9'h003: hdr_b = kind_q ? lrf_pkg::TYPE_IO64 : lrf_pkg::TYPE_RX16;
      default: begin
        if (!kind_q) begin
          case (idx_q) // RL4
            9'h004: hdr_b = src_q[15:8];
            9'h005: hdr_b = src_q[7:0];
            9'h006: hdr_b = rssi_q;
            default: hdr_b = opt_q;
          endcase
        end else if (idx_q <= lrf_pkg::LONG_LAST) begin
          hdr_b = long_q[{lsel, 3'b000} +: 8]; // RL10
        end else begin
          case (idx_q) // RL10
            9'h00c: hdr_b = rssi_q;
            9'h00d: hdr_b = opt_q;
            9'h00e: hdr_b = lrf_pkg::SAMPLE_SETS;
            9'h00f: hdr_b = mask_q[15:8];
            default: hdr_b = mask_q[7:0];
          endcase
        end
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    {kind_d, src_d, long_d, raw_d, rssi_d} = {kind_q, src_q, long_q,
                                              raw_q, rssi_q};
    {opt_d, mask_d, len_d} = {opt_q, mask_q, len_q};
    {tail_d, tail_n_d, left_d, idx_d} = {tail_q, tail_n_q, left_q, idx_q};
    load = 1'b0;
    byte_v = hdr_b;
    frame_done = 1'b0;
    drop_evt = 1'b0;
    sum.clr = 1'b0;
    unique case (state_q)
      lrf_pkg::ST_IDLE: begin
        if (i_pkt_valid) begin
          kind_d = i_pkt_kind;
          src_d = i_src_short;
          long_d = i_src_long;
          raw_d = i_rssi_dbm;
          rssi_d = rssi_mag;
          opt_d = {5'h00, i_bcast_all_net, i_bcast, 1'b0}; // RL6
          mask_d = {3'h0, i_chan_mask[12:0]}; // RL11
          tail_d = tail_v;
          tail_n_d = tail_n;
          left_d = i_pay_len;
          idx_d = 9'h000;
          len_d = i_pkt_kind ? lrf_pkg::SAMP_LEN_BASE + 16'(tail_n)
                             : lrf_pkg::DATA_LEN_BASE + 16'(i_pay_len);
          if (emit_ok && (want16 || want64)) begin // RL1 RL8 RL9
            state_d = lrf_pkg::ST_HEAD;
            sum.clr = 1'b1;
          end else begin
            drop_evt = 1'b1;
            if (!i_pkt_kind && i_pay_len != '0) begin
              state_d = lrf_pkg::ST_DROP;
            end
          end
        end
      end
      lrf_pkg::ST_HEAD: begin
        if (slot_free) begin
          load = 1'b1;
          idx_d = idx_q + 9'h001;
          if (kind_q && idx_q == lrf_pkg::SAMP_HDR_LAST) begin
            state_d = (tail_n_q != 4'h0) ? lrf_pkg::ST_TAIL
                                         : lrf_pkg::ST_SUM;
          end else if (!kind_q && idx_q == lrf_pkg::DATA_HDR_LAST) begin
            state_d = (left_q != '0) ? lrf_pkg::ST_PAY : lrf_pkg::ST_SUM;
          end
        end
      end
      lrf_pkg::ST_PAY: begin
        byte_v = i_pay_data; // RL4
        if (slot_free && i_pay_valid) begin
          load = 1'b1;
          idx_d = idx_q + 9'h001;
          left_d = left_q - 1'b1;
          if (left_q == PAY_W'(1)) begin
            state_d = lrf_pkg::ST_SUM;
          end
        end
      end
      lrf_pkg::ST_TAIL: begin
        byte_v = tail_q[lrf_pkg::TAIL_W-1 -: 8]; // RL13
        if (slot_free) begin
          load = 1'b1;
          idx_d = idx_q + 9'h001;
          tail_d = {tail_q[lrf_pkg::TAIL_W-9:0], 8'h00};
          tail_n_d = tail_n_q - 4'h1;
          if (tail_n_q == 4'h1) begin
            state_d = lrf_pkg::ST_SUM;
          end
        end
      end
      lrf_pkg::ST_SUM: begin
        byte_v = sum.csum; // RL7
        if (slot_free) begin
          load = 1'b1;
          frame_done = 1'b1;
          state_d = lrf_pkg::ST_IDLE;
        end
      end
      lrf_pkg::ST_DROP: begin
        if (i_pay_valid) begin
          left_d = left_q - 1'b1;
          if (left_q == PAY_W'(1)) begin
            state_d = lrf_pkg::ST_IDLE;
          end
        end
      end
      default: state_d = lrf_pkg::ST_IDLE;
    endcase
    tx_valid_d = tx_valid_q && !i_tx_ready;
    tx_data_d = tx_data_q;
    pos_d = pos_q;
    last_d = last_q;
    if (load) begin
      tx_valid_d = 1'b1;
      tx_data_d = byte_v;
      pos_d = idx_q;
      last_d = (state_q == lrf_pkg::ST_SUM);
    end
  end

  assign sum.add = load && idx_q >= lrf_pkg::SUM_FIRST && // RL7
                   state_q != lrf_pkg::ST_SUM;
  assign sum.data = byte_v;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= lrf_pkg::ST_IDLE;
      {kind_q, src_q, long_q, raw_q, rssi_q} <= '0;
      {opt_q, mask_q, len_q} <= '0;
      {tail_q, tail_n_q, left_q, idx_q} <= '0;
      {tx_valid_q, tx_data_q, pos_q, last_q} <= '0;
    end else begin
      state_q <= state_d;
      {kind_q, src_q, long_q, raw_q, rssi_q} <= {kind_d, src_d, long_d,
                                                 raw_d, rssi_d};
      {opt_q, mask_q, len_q} <= {opt_d, mask_d, len_d};
      {tail_q, tail_n_q, left_q, idx_q} <= {tail_d, tail_n_d, left_d,
                                            idx_d};
      {tx_valid_q, tx_data_q, pos_q, last_q} <= {tx_valid_d, tx_data_d,
                                                 pos_d, last_d};
    end
  end

  assign o_pkt_ready = (state_q == lrf_pkg::ST_IDLE);
  assign o_pay_ready = (state_q == lrf_pkg::ST_PAY && slot_free) ||
                       (state_q == lrf_pkg::ST_DROP);
  assign o_tx_valid = tx_valid_q;
  assign o_tx_data = tx_data_q;

  // Independent sum of the bytes that actually left, for checking.
  logic [7:0] acc_q, acc_d;
  logic [15:0] seen_len_q, seen_len_d;
  logic acc_take;
  assign acc_take = o_tx_valid && i_tx_ready;
  // The length is taken from the bytes that left, since len_q may already
  // hold the next packet while a checksum byte still waits.
  always_comb begin
    acc_d = acc_q;
    seen_len_d = seen_len_q;
    if (acc_take) begin
      acc_d = (pos_q < lrf_pkg::SUM_FIRST) ? 8'h00 : acc_q + o_tx_data;
      if (pos_q == 9'h001) begin
        seen_len_d[15:8] = o_tx_data;
      end
      if (pos_q == 9'h002) begin
        seen_len_d[7:0] = o_tx_data;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_q <= 8'h00;
      seen_len_q <= 16'h0000;
    end else begin
      acc_q <= acc_d;
      seen_len_q <= seen_len_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_out(int p);
    o_tx_valid && i_tx_ready && !last_q && pos_q == 9'(p);
  endsequence
  sequence s_take;
    i_pkt_valid && o_pkt_ready;
  endsequence

  property p_delim;
    s_out(0) |-> o_tx_data == lrf_pkg::START_DELIM;
  endproperty
  a_delim: assert property (p_delim) else $error("bad start byte"); // RL2
  property p_len;
    o_tx_valid && last_q |-> pos_q == seen_len_q[8:0] + lrf_pkg::SUM_FIRST;
  endproperty
  a_len: assert property (p_len) else $error("length mismatch"); // RL2
  property p_type16;
    s_out(3) ##0 !kind_q |-> o_tx_data == lrf_pkg::TYPE_RX16;
  endproperty
  a_type16: assert property (p_type16) else $error("bad 0x81 type"); // RL3
  property p_type64;
    s_out(3) ##0 kind_q |-> o_tx_data == lrf_pkg::TYPE_IO64;
  endproperty
  a_type64: assert property (p_type64) else $error("bad 0x82 type"); // RL8
  property p_src16;
    s_out(4) ##0 !kind_q |-> o_tx_data == src_q[15:8];
  endproperty
  a_src16: assert property (p_src16) else $error("bad source"); // RL4
  property p_rssi;
    s_out(6) ##0 (!kind_q && raw_q[7]) |-> 8'(o_tx_data + raw_q) == 8'h00;
  endproperty
  a_rssi: assert property (p_rssi) else $error("bad strength"); // RL5
  property p_opt;
    s_out(7) ##0 !kind_q |-> o_tx_data[0] == 1'b0 && o_tx_data[7:3] == 5'h0;
  endproperty
  a_opt: assert property (p_opt) else $error("bad options"); // RL6
  property p_sum;
    o_tx_valid && i_tx_ready && last_q |-> 8'(acc_q + o_tx_data) == 8'hff;
  endproperty
  a_sum: assert property (p_sum) else $error("bad checksum"); // RL7
  property p_gate;
    s_take ##1 state_q == lrf_pkg::ST_HEAD |->
      $past(api_q) && $past(fmt_q) == lrf_pkg::FMT_LEGACY;
  endproperty
  a_gate: assert property (p_gate) else $error("frame while gated"); // RL9
  property p_rx16;
    s_take and (emit_ok && want16) |=> state_q == lrf_pkg::ST_HEAD;
  endproperty
  a_rx16: assert property (p_rx16) else $error("packet not framed"); // RL1
  property p_sets;
    s_out(14) ##0 kind_q |-> o_tx_data == lrf_pkg::SAMPLE_SETS;
  endproperty
  a_sets: assert property (p_sets) else $error("bad set count"); // RL10
  property p_mask;
    s_out(15) ##0 kind_q |-> o_tx_data[7:5] == 3'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("unused mask set"); // RL11
  property p_dig;
    s_take and (i_pkt_kind && i_chan_mask[8:0] == 9'h000) |=>
      tail_n_q == 4'(2 * $countones($past(i_chan_mask[12:9])));
  endproperty
  a_dig: assert property (p_dig) else $error("digital word present"); // RL12
endmodule
`default_nettype wire

// ===== lrf_host.sv
// Host side model that takes frame bytes and checks their framing.
`timescale 1ns/1ps
`default_nettype none
module lrf_host (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Frame byte stream.
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Stall control.
  input wire logic i_slow
);
  logic [7:0] rx_q[$];
  int bad_cnt = 0;
  int seed = 54;
  int pos = 0;
  logic [7:0] sum = 8'h00;
  logic [15:0] len = 16'h0000;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_ready <= 1'b0;
      pos = 0;
    end else begin
      if (i_tx_valid && o_tx_ready) begin
        rx_q.push_back(i_tx_data);
        if (pos == 0) begin
          if (i_tx_data == 8'h7e) pos = 1;
        end else if (pos == 1) begin
          len[15:8] = i_tx_data;
          pos = 2;
        end else if (pos == 2) begin
          len[7:0] = i_tx_data;
          sum = 8'h00;
          pos = 3;
        end else if (pos < len + 3) begin
          sum += i_tx_data;
          pos++;
        end else begin
          if (8'(sum + i_tx_data) !== 8'hff) bad_cnt++;
          pos = 0;
        end
      end
      // A slow host stalls the stream on most cycles.
      o_tx_ready <= !i_slow || (($random(seed) & 3) == 0);
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench of the legacy receive frame builder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0] i_pstrb;
  logic i_pkt_valid, o_pkt_ready, i_pkt_kind, i_bcast, i_bcast_all_net;
  logic [15:0] i_src_short, i_chan_mask, i_dig_samples;
  logic [63:0] i_src_long, i_analog;
  logic [7:0] i_rssi_dbm, i_pay_len, i_pay_data, o_tx_data;
  logic i_pay_valid, o_pay_ready, o_tx_valid, i_tx_ready, slow;
  logic [7:0] exp_q[$];
  logic [7:0] pay_q[$];
  logic [31:0] rd;
  logic er;
  int seed = 54;
  int pseed = 54;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int npkt = 0;
  int nfrm = 0;
  int ndrop = 0;
  logic [15:0] masks[6] = '{16'h0000, 16'h01ff, 16'h1e00, 16'hffff,
                            16'h0101, 16'h0a00};
  lrf_builder i_dut (.i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr,
    .i_pkt_valid, .o_pkt_ready, .i_pkt_kind, .i_src_short, .i_src_long,
    .i_rssi_dbm, .i_bcast, .i_bcast_all_net, .i_pay_len, .i_chan_mask,
    .i_dig_samples, .i_analog, .i_pay_valid, .o_pay_ready, .i_pay_data,
    .o_tx_valid, .i_tx_ready, .o_tx_data);
  lrf_host h (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .i_slow(slow));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    i_pstrb <= 4'hf;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  // Expected frame around a body: delimiter, length, body, checksum.
  function automatic void frame(input logic [7:0] b[$]);
    logic [7:0] s;
    s = 8'h00;
    exp_q.push_back(8'h7e);
    exp_q.push_back(8'(b.size() >> 8));
    exp_q.push_back(8'(b.size()));
    foreach (b[k]) begin
      exp_q.push_back(b[k]);
      s += b[k];
    end
    exp_q.push_back(8'hff - s);
  endfunction
  task automatic send(input logic k, input logic [15:0] s,
                      input logic [7:0] n, input logic [15:0] m,
                      input logic on);
    logic [63:0] l, an;
    logic [7:0] r, x;
    logic [15:0] d;
    logic [1:0] o;
    logic [7:0] b[$];
    l = {$random(seed), $random(seed)};
    an = {$random(seed), $random(seed)};
    r = {npkt % 5 != 0, 7'($random(seed))};
    d = 16'($random(seed));
    o = 2'(npkt);
    npkt++;
    b.push_back(k ? 8'h82 : 8'h81);
    if (k) for (int i = 7; i >= 0; i--) b.push_back(l[8*i+:8]);
    else begin
      b.push_back(s[15:8]);
      b.push_back(s[7:0]);
    end
    b.push_back(r[7] ? 8'h00 - r : 8'h00);
    b.push_back({5'h00, o, 1'b0});
    if (k) begin
      b.push_back(8'h01);
      b.push_back({3'h0, m[12:8]});
      b.push_back(m[7:0]);
      if (m[8:0] != 9'h000) begin
        b.push_back({7'h00, d[8] & m[8]});
        b.push_back(d[7:0] & m[7:0]);
      end
      for (int c = 0; c < 4; c++) begin
        if (m[9+c]) begin
          b.push_back(an[16*c+8+:8]);
          b.push_back(an[16*c+:8]);
        end
      end
    end
    for (int i = 0; i < n; i++) begin
      x = 8'($random(seed));
      pay_q.push_back(x);
      if (!k) b.push_back(x);
    end
    if (on) begin
      frame(b);
      nfrm++;
    end else ndrop++;
    i_pkt_kind <= k;
    i_src_short <= s;
    i_src_long <= l;
    i_rssi_dbm <= r;
    i_bcast <= o[0];
    i_bcast_all_net <= o[1];
    i_pay_len <= n;
    i_chan_mask <= m;
    i_dig_samples <= d;
    i_analog <= an;
    i_pkt_valid <= 1'b1;
    do @(posedge i_clk); while (o_pkt_ready !== 1'b1);
    i_pkt_valid <= 1'b0;
    @(posedge i_clk);
  endtask
  // Payload source holds each offered byte until it is taken.
  always @(posedge i_clk) begin
    if (i_pay_valid && o_pay_ready) void'(pay_q.pop_front());
    if (!i_pay_valid || o_pay_ready) begin
      if (pay_q.size() > 0 && ($random(pseed) & 1)) begin
        i_pay_valid <= 1'b1;
        i_pay_data <= pay_q[0];
      end else i_pay_valid <= 1'b0;
    end
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    logic [15:0] s;
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} = '0;
    {i_pkt_valid, i_pkt_kind, i_src_short, i_src_long, i_rssi_dbm} = '0;
    {i_bcast, i_bcast_all_net, i_pay_len, i_chan_mask} = '0;
    {i_dig_samples, i_analog, i_pay_valid, i_pay_data, slow} = '0;
    repeat (16) @(posedge i_clk);
    chk("tx valid in reset", 32'h0, {31'h0, o_tx_valid});
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    send(1'b1, 16'hfffe, 8'h00, 16'h1fff, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0002);
    send(1'b1, 16'hfffe, 8'h00, 16'h0203, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0101);
    send(1'b0, 16'h0042, 8'h02, 16'h0000, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0102);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h0000_0102, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h008, 32'hffff_ffff);
    send(1'b0, 16'hfffd, 8'h00, 16'h0000, 1'b1);
    send(1'b0, 16'hfffe, 8'h03, 16'h0000, 1'b0);
    send(1'b1, 16'h1234, 8'h00, 16'h1fff, 1'b0);
    foreach (masks[i]) send(1'b1, 16'hfffe, 8'h00, masks[i], 1'b1);
    for (int i = 0; i < 24; i++) begin
      slow <= i[1];
      s = 16'($random(seed));
      if (s >= 16'hfffe) s = 16'h0001;
      if (i[0]) send(1'b1, 16'hfffe, 8'h00, 16'($random(seed)), 1'b1);
      else send(1'b0, s, 8'(i % 7), 16'h0000, 1'b1);
    end
    for (int w = 0; w < 3000 && (h.rx_q.size() < exp_q.size()
         || o_pkt_ready !== 1'b1); w++) @(posedge i_clk);
    chk("frame bytes", 32'(exp_q.size()), 32'(h.rx_q.size()));
    foreach (exp_q[i]) begin
      if (i < h.rx_q.size()) chk("byte", exp_q[i], h.rx_q[i]);
    end
    chk("bad checksums", 32'h0, 32'(h.bad_cnt));
    chk("payload left", 32'h0, 32'(pay_q.size()));
    apb(1'b0, 12'h008, 32'h0);
    chk("frames", 32'(nfrm), rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("drops", 32'(ndrop), rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h0, rd);
    print_verdict();
  end
endmodule
`default_nettype wire
